/* rtl/sas_pkg.sv */
// Summary of operation
// - software picks reference: supply rails or external reference pins
// - conversion runs in sleep only when clocked from the internal rc clock
// - sample-and-hold feeds an sar engine resolving one bit per bit_period
// - each shared pin is set analog input or digital i/o on its own
// - on completion load result pair, clear start bit, set complete flag
// - device reset restores registers, turns module off, aborts conversion
// - device reset leaves result pair untouched; power-on reset clears it to zero
// - optional programmed acquisition interval between start bit and conversion
// - at least two bit_periods after conversion before next acquisition
// - clock select: osc/2,4,8,16,32,64 or internal rc for x11
// - acquisition field selects 2 to 20 bit_periods; 000 starts at once, except on rc clock one instruction cycle later
// - a 10-bit conversion takes eleven bit_periods
// - after conversion sampling resumes with no phase indication
package sas_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_RESULT_HIGH = 3'h0;
  localparam logic [2:0] OFF_RESULT_LOW  = 3'h1;
  localparam logic [2:0] OFF_CONV_CTRL   = 3'h2;
  localparam logic [2:0] OFF_PIN_REF     = 3'h3;
  localparam logic [2:0] OFF_TIMING      = 3'h4;
  localparam logic [2:0] OFF_STATUS      = 3'h5;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT    = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_CH_LSB    = 2;
  localparam int PIN_REFN_BIT   = 4;
  localparam int PIN_REFP_BIT   = 5;
  localparam int PIN_CFG_LSB    = 0;
  localparam int TIM_CS_LSB     = 0;
  localparam int TIM_ACQ_LSB    = 3;
  localparam int TIM_RIGHT_BIT  = 7;
  localparam int STAT_FLAG_BIT  = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [7:0] PIN_REF_RST   = 8'h00;
  localparam logic [7:0] TIMING_RST    = 8'h00;
  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int CONV_BIT_PERIODS = 11;
  localparam int SETTLE_PERIODS   = 2;
  localparam int CLOCK_NS         = 4;
  localparam int INSTR_CYCLE_NS   = 16;
  localparam int INSTR_CYCLES     = (INSTR_CYCLE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int RC_DIV           = 300;
  typedef enum logic [2:0] {
    SAS_IDLE, SAS_RC_DLY, SAS_ACQ, SAS_CONV, SAS_SETTLE
  } sas_state_e;
endpackage : sas_pkg

/* rtl/sas_sar_adc_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module sas_sar_adc_sequencer #(
  parameter int RC_DIV_P = sas_pkg::RC_DIV
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       por_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       sleep_mode,
  input  wire logic       cmp_high,
  output logic            sample_en,
  output logic      [9:0] dac_code,
  output logic      [1:0] channel_sel,
  output logic            ref_pos_ext,
  output logic            ref_neg_ext,
  output logic      [3:0] pin_analog,
  output logic            conv_complete_flag
);
  import sas_pkg::*;
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d, pinref_q, pinref_d, tim_q, tim_d, rdata_d;
  logic       flag_q, flag_d;
  logic [9:0] result_q, result_d, sar_q, sar_d;
  sas_state_e st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] div_q, div_d;
  logic       tick, done, busy;
  logic [2:0] cs;
  logic [2:0] acq;
  logic [4:0] acq_len;
  logic       rc_sel;

  assign cs     = tim_q[TIM_CS_LSB +: 3];
  assign acq    = tim_q[TIM_ACQ_LSB +: 3];
  assign rc_sel = (cs[1:0] == 2'b11);
  assign busy   = (st_q != SAS_IDLE) && (st_q != SAS_SETTLE);

  // acquisition length in bit periods
  always_comb begin
    unique case (acq)
      3'd0:    acq_len = 5'd0;
      3'd1:    acq_len = 5'd2;
      3'd2:    acq_len = 5'd4;
      3'd3:    acq_len = 5'd6;
      3'd4:    acq_len = 5'd8;
      3'd5:    acq_len = 5'd12;
      3'd6:    acq_len = 5'd16;
      default: acq_len = 5'd20;
    endcase
  end

  // ----------------------------------------------------------------
  // bit period divider
  // ----------------------------------------------------------------
  // divider halted in sleep unless rc clock selected; osc stops then
  always_comb begin
    logic [8:0] lim;
    lim = 9'd1;
    unique case (cs)
      3'b000:  lim = 9'd1;
      3'b100:  lim = 9'd3;
      3'b001:  lim = 9'd7;
      3'b101:  lim = 9'd15;
      3'b010:  lim = 9'd31;
      3'b110:  lim = 9'd63;
      default: lim = 9'(RC_DIV_P - 1);
    endcase
    tick  = (div_q >= lim);
    div_d = tick ? 9'd0 : div_q + 9'd1;
    if ((sleep_mode && !rc_sel) || st_q == SAS_IDLE || st_q == SAS_RC_DLY) begin
      div_d = 9'd0;
      tick  = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 9'd0;
    end else begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and sar engine
  // ----------------------------------------------------------------
  // one test bit resolved per tick, msb first
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    sar_d = sar_q;
    done  = 1'b0;
    unique case (st_q)
      SAS_IDLE: begin
        if (ctrl_q[CTRL_START_BIT] && ctrl_q[CTRL_ON_BIT]) begin
          cnt_d = 5'd0;
          if (rc_sel) begin
            st_d = SAS_RC_DLY;
          end else if (acq_len != 5'd0) begin
            st_d = SAS_ACQ;
          end else begin
            st_d  = SAS_CONV;
            bit_d = 4'd0;
            sar_d = 10'h200;
          end
        end
      end
      SAS_RC_DLY: begin
        cnt_d = cnt_q + 5'd1;
        if (cnt_q == 5'(INSTR_CYCLES - 1)) begin
          cnt_d = 5'd0;
          st_d  = (acq_len != 5'd0) ? SAS_ACQ : SAS_CONV;
          bit_d = 4'd0;
          sar_d = 10'h200;
        end
      end
      SAS_ACQ: begin
        if (tick) begin
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == acq_len - 5'd1) begin
            st_d  = SAS_CONV;
            bit_d = 4'd0;
            sar_d = 10'h200;
          end
        end
      end
      SAS_CONV: begin
        if (tick) begin
          bit_d = bit_q + 4'd1;
          if (bit_q < 4'd10) begin
            if (!cmp_high) begin
              sar_d[4'd9 - bit_q] = 1'b0;
            end
            if (bit_q < 4'd9) begin
              sar_d[4'd8 - bit_q] = 1'b1;
            end
          end
          if (bit_q == 4'(CONV_BIT_PERIODS - 1)) begin
            done  = 1'b1;
            st_d  = SAS_SETTLE;
            cnt_d = 5'd0;
          end
        end
      end
      SAS_SETTLE: begin
        if (tick) begin
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == 5'(SETTLE_PERIODS - 1)) begin
            st_d = SAS_IDLE;
          end
        end
      end
      default: st_d = SAS_IDLE;
    endcase
    if (!ctrl_q[CTRL_ON_BIT]) begin
      st_d = SAS_IDLE; // switching off aborts
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= SAS_IDLE;
      cnt_q <= 5'd0;
      bit_q <= 4'd0;
      sar_q <= 10'h000;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sar_q <= sar_d;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d   = ctrl_q;
    pinref_d = pinref_q;
    tim_d    = tim_q;
    flag_d   = flag_q;
    result_d = result_q;
    if (wr_en) begin
      unique case (addr)
        OFF_CONV_CTRL: ctrl_d   = wdata;
        OFF_PIN_REF:   pinref_d = wdata;
        OFF_TIMING:    tim_d    = wdata;
        OFF_STATUS:    flag_d   = wdata[STAT_FLAG_BIT];
        default:       ;
      endcase
    end
    // also forced on the entry edge, so a racing write cannot drop it
    if (busy || (st_d != SAS_IDLE && st_d != SAS_SETTLE)) begin
      ctrl_d[CTRL_START_BIT] = 1'b1;
    end
    if (!ctrl_d[CTRL_ON_BIT]) begin
      ctrl_d[CTRL_START_BIT] = 1'b0;
    end
    if (done) begin
      result_d               = sar_d;
      ctrl_d[CTRL_START_BIT] = 1'b0;
      flag_d                 = 1'b1; // set wins over clear
    end
    rdata_d = 8'h00;
    if (rd_en) begin
      unique case (addr)
        OFF_RESULT_HIGH: rdata_d = tim_q[TIM_RIGHT_BIT] ? {6'h00, result_q[9:8]}
                                                        : result_q[9:2];
        OFF_RESULT_LOW:  rdata_d = tim_q[TIM_RIGHT_BIT] ? result_q[7:0]
                                                        : {result_q[1:0], 6'h00};
        OFF_CONV_CTRL:   rdata_d = ctrl_q;
        OFF_PIN_REF:     rdata_d = pinref_q;
        OFF_TIMING:      rdata_d = tim_q;
        OFF_STATUS:      rdata_d = {7'h00, flag_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= CONV_CTRL_RST;
      pinref_q <= PIN_REF_RST;
      tim_q    <= TIMING_RST;
      flag_q   <= 1'b0;
      rdata    <= 8'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      pinref_q <= pinref_d;
      tim_q    <= tim_d;
      flag_q   <= flag_d;
      rdata    <= rdata_d;
    end
  end

  // result pair only reset by power-on, never by device reset
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      result_q <= 10'h000;
    end else begin
      result_q <= result_d;
    end
  end

  // ----------------------------------------------------------------
  // analog side outputs
  // ----------------------------------------------------------------
  // sampling resumes after every conversion, no phase flag
  assign sample_en          = ctrl_q[CTRL_ON_BIT] && (st_q != SAS_CONV);
  assign dac_code           = sar_q;
  assign channel_sel        = ctrl_q[CTRL_CH_LSB +: 2];
  assign ref_pos_ext        = pinref_q[PIN_REFP_BIT];
  assign ref_neg_ext        = pinref_q[PIN_REFN_BIT];
  assign pin_analog         = pinref_q[PIN_CFG_LSB +: 4];
  assign conv_complete_flag = flag_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_last_tick;
    (st_q == SAS_CONV) && tick && (bit_q == 4'd10);
  endsequence
  property p_done_load;
    @(posedge clock) disable iff (!rst_n)
      s_last_tick |=> conv_complete_flag && !ctrl_q[CTRL_START_BIT] && (st_q == SAS_SETTLE);
  endproperty
  a_done_load: assert property (p_done_load) else $error("completion not signalled");
  property p_start_held;
    @(posedge clock) disable iff (!rst_n)
      busy && ctrl_q[CTRL_ON_BIT] |-> ctrl_q[CTRL_START_BIT];
  endproperty
  a_start_held: assert property (p_start_held) else $error("start bit dropped early");
  property p_rc_delay;
    @(posedge clock) disable iff (!rst_n)
      (st_q == SAS_IDLE) && ctrl_q[CTRL_ON_BIT] && ctrl_q[CTRL_START_BIT] && rc_sel
      |=> (st_q == SAS_RC_DLY);
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("rc start not delayed");
  property p_sleep_hold;
    @(posedge clock) disable iff (!rst_n)
      sleep_mode && !rc_sel |-> !tick;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("ran in sleep off rc");
  property p_no_acq;
    @(posedge clock) disable iff (!rst_n)
      (st_q == SAS_IDLE) && ctrl_q[CTRL_ON_BIT] && ctrl_q[CTRL_START_BIT] && !rc_sel
      && (acq == 3'd0) |=> (st_q == SAS_CONV) && (bit_q == 4'd0);
  endproperty
  a_no_acq: assert property (p_no_acq) else $error("manual start not immediate");
  property p_settle;
    @(posedge clock) disable iff (!rst_n)
      (st_q == SAS_IDLE) && ($past(st_q) == SAS_SETTLE) && $past(ctrl_q[CTRL_ON_BIT])
      |-> $past(tick) && ($past(cnt_q) == 5'(SETTLE_PERIODS - 1));
  endproperty
  a_settle: assert property (p_settle) else $error("settle skipped");
endmodule : sas_sar_adc_sequencer
`default_nettype wire

/* tb/sas_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model (
  input  wire logic [1:0]  channel_sel,
  input  wire logic [9:0]  dac_code,
  input  wire logic [39:0] vin_flat,
  output logic             cmp_high
);
  // pins are only sensed, never driven: port_direction input
  // ideal comparator on the selected pin; trial bit kept at or above code
  always_comb begin
    cmp_high = (vin_flat[channel_sel*10 +: 10] >= dac_code);
  end
endmodule : sas_analog_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sas_pkg::*;
  localparam int RCD = 4;
  logic        clock = 0, rst_n = 0, por_n = 0, wr_en = 0, rd_en = 0, sleep_mode = 0;
  logic [2:0]  addr = 0;
  logic [7:0]  wdata = 0, rdata;
  logic        cmp_high, sample_en, ref_pos_ext, ref_neg_ext, conv_complete_flag;
  logic [9:0]  dac_code;
  logic [1:0]  channel_sel;
  logic [3:0]  pin_analog;
  logic [39:0] vin_flat = 0;
  int          errors = 0, n_tests = 0, seed = 32'h1f1e_a058;
  int          acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int          div_tab[8] = '{2, 8, 32, RCD, 4, 16, 64, RCD};
  logic [7:0]  d, q;
  int          n;
  int          exp_q[$];
  always #2 clock = ~clock;
  sas_sar_adc_sequencer #(.RC_DIV_P(RCD)) i_dut (.clock(clock), .rst_n(rst_n), .por_n(por_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .sleep_mode(sleep_mode), .cmp_high(cmp_high), .sample_en(sample_en), .dac_code(dac_code),
    .channel_sel(channel_sel), .ref_pos_ext(ref_pos_ext), .ref_neg_ext(ref_neg_ext),
    .pin_analog(pin_analog), .conv_complete_flag(conv_complete_flag));
  sas_analog_model i_ana (.channel_sel(channel_sel), .dac_code(dac_code), .vin_flat(vin_flat),
    .cmp_high(cmp_high));
  // ------------------------------------------------
  // bus tasks; each is entered just after a rising edge
  // ------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    addr <= a; wdata <= v; wr_en <= 1'b1;
    @(posedge clock); wr_en <= 1'b0;
    @(posedge clock);
  endtask : wr
  // gap cycle keeps strobe edges one per time step
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    addr <= a; rd_en <= 1'b1;
    @(posedge clock); rd_en <= 1'b0;
    @(negedge clock); v = rdata;
    @(posedge clock);
  endtask : rd
  task automatic wait_done(output int cnt);
    logic [7:0] s;
    cnt = 0; s = 8'h02;
    while (s[1] && cnt < 5000) begin
      rd(3'h2, s); // poll start bit
      cnt += 2;
    end
  endtask : wait_done
  // one conversion: timing window, result pairing, flag set and clear
  task automatic conv(input logic [2:0] cs, input logic [2:0] aq, input logic rj);
    int tt, p, k;
    logic [9:0] v;
    logic [1:0] ch;
    ch = aq[1:0];
    exp_q.push_back(int'(vin_flat[ch*10 +: 10]));
    p = div_tab[cs];
    tt = (acq_tab[aq] + 11) * p + ((cs[1:0] == 2'b11) ? 4 : 0);
    wr(3'h5, 8'h00); // flag cleared before start
    wr(3'h4, {rj, 1'b0, aq, cs});
    wr(3'h2, {4'h0, ch, 2'b11});
    @(negedge clock);
    chk("chan", 16'(channel_sel), 16'(ch));
    @(posedge clock);
    wait_done(k);
    v = 10'(exp_q.pop_front());
    chk("busy_len", 16'(k >= tt - 2 && k <= tt + p + 6), 16'h0001);
    rd(3'h0, d); chk("res_hi", 16'(d), 16'(rj ? {6'h00, v[9:8]} : v[9:2]));
    rd(3'h1, d); chk("res_lo", 16'(d), 16'(rj ? v[7:0] : {v[1:0], 6'h00}));
    rd(3'h5, d); chk("flag", 16'(d[0]), 16'h0001);
    @(negedge clock);
    chk("sample_idle", 16'(sample_en), 16'h0001);
    chk("dac", 16'(dac_code), 16'(v));
    chk("flag_pin", 16'(conv_complete_flag), 16'h0001);
    @(posedge clock);
    wr(3'h5, 8'h00); rd(3'h5, d); chk("flag_clr", 16'(d[0]), 16'h0000);
    repeat (2 * p + 4) @(posedge clock);
  endtask : conv
  // ------------------------------------------------
  // main sequence and verdict
  // ------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // long divide codes dominate; limit sits well past them
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1; por_n <= 1'b1;
    @(posedge clock);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d); chk("reset_val", 16'(d), 16'h0000);
    end
    $display("test reset done");
    wr(3'h3, 8'h3a); rd(3'h3, d); chk("pinref", 16'(d), 16'h003a);
    @(negedge clock);
    chk("pins", 16'({ref_pos_ext, ref_neg_ext, pin_analog}), 16'h003a);
    @(posedge clock);
    wr(3'h3, 8'h05);
    @(negedge clock);
    chk("pins2", 16'({ref_pos_ext, ref_neg_ext, pin_analog}), 16'h0005);
    @(posedge clock);
    $display("test config done");
    for (int i = 0; i < 8; i++) begin
      vin_flat <= 40'({$random(seed), $random(seed)}); // settled well before start
      sleep_mode <= (i[1:0] == 2'b11);
      @(posedge clock);
      conv(i[2:0], i[2:0], i[0]);
    end
    $display("test convert done");
    sleep_mode <= 1'b1;
    exp_q.push_back(int'(vin_flat[9:0]));
    wr(3'h4, 8'h00); wr(3'h2, 8'h03);
    repeat (60) @(posedge clock);
    rd(3'h2, d); chk("sleep_hold", 16'(d[1]), 16'h0001);
    @(negedge clock);
    chk("sample_busy", 16'(sample_en), 16'h0000);
    @(posedge clock);
    sleep_mode <= 1'b0;
    wait_done(n);
    chk("wake_done", 16'(n < 40), 16'h0001);
    rd(3'h0, d); chk("sleep_res", 16'(d), 16'(exp_q.pop_front() >> 2));
    $display("test sleep done");
    wr(3'h2, 8'h03);
    repeat (4) @(posedge clock);
    rst_n <= 1'b0; @(posedge clock); rst_n <= 1'b1; @(posedge clock);
    @(negedge clock);
    chk("abort_on", 16'(sample_en), 16'h0000);
    @(posedge clock);
    rd(3'h2, q); chk("abort_ctrl", 16'(q), 16'h0000);
    rd(3'h0, q); chk("kept_hi", 16'(q), 16'(d));
    por_n <= 1'b0; @(posedge clock); por_n <= 1'b1; @(posedge clock);
    rd(3'h0, d); chk("por_hi", 16'(d), 16'h0000);
    $display("test reset_abort done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
